// ---- hw/ring_pkg.sv ----
/*
 * shared constants and carrier types for the packed ring engine:
 * descriptor layout, flag bits, suppression encoding, register map.
 * assumes a single 125 MHz clock domain and a simple memory port.
 */
package ring_pkg;
    // ************************************************************
    // descriptor layout
    // ************************************************************
    localparam int DESC_BYTES      = 16;           // bytes per ring slot
    localparam int DESC_ALIGN      = 16;           // ring base alignment
    localparam int SUPP_BYTES      = 4;            // suppression structure size
    localparam int SUPP_ALIGN      = 4;            // suppression alignment
    localparam int FLAG_CONT       = 0;            // continuation_flag bit
    localparam int FLAG_WR         = 1;            // device_writable_flag bit (value 2)
    localparam int FLAG_IND        = 2;            // indirect_table_flag bit
    localparam int FLAG_AVAIL      = 7;            // available_flag bit
    localparam int FLAG_USED       = 15;           // used_flag bit
    localparam int OFF_BITS        = 15;           // event offset width
    localparam int MAX_CHAIN       = 8;            // device limit per list
    // suppression flag codes
    localparam logic [1:0] EVT_ENABLE  = 2'h0;
    localparam logic [1:0] EVT_DISABLE = 2'h1;
    localparam logic [1:0] EVT_DESC    = 2'h2;
    // ************************************************************
    // register map (word offsets)
    // ************************************************************
    localparam logic [3:0] REG_CTRL     = 4'h0;    // bit0 run, bit1 event idx feature
    localparam logic [3:0] REG_RING_LO  = 4'h1;    // ring base low
    localparam logic [3:0] REG_RING_HI  = 4'h2;    // ring base high
    localparam logic [3:0] REG_QSIZE    = 4'h3;    // queue size
    localparam logic [3:0] REG_DRV_EVT  = 4'h4;    // driver suppression address low
    localparam logic [3:0] REG_DEV_EVT  = 4'h5;    // own suppression word
    localparam logic [3:0] REG_STATUS   = 4'h6;    // used and available positions and wraps
    localparam logic [3:0] REG_COMPLETE = 4'h7;    // write: id of completed buffer
    localparam logic [3:0] REG_ERRORS   = 4'h8;    // sticky error bits
    localparam logic [3:0] REG_NOTIFY   = 4'h9;    // driver notify: off/wrap
    localparam int CTRL_RUN = 0;
    localparam int CTRL_EVI = 1;
    localparam int ERR_CHAIN = 0;                  // list longer than limit
    localparam int ERR_IND   = 1;                  // indirect inside list
    localparam int ERR_ALIGN = 2;                  // misaligned bases
    localparam int ERR_SUPP  = 3;                  // reserved suppression code
    localparam logic [15:0] QSIZE_RST = 16'h0100;  // default queue size

    // memory request: one 64-bit beat, byte address
    typedef struct packed {
        logic        wr;
        logic [63:0] addr;
        logic [63:0] wdata;
        logic [7:0]  be;
    } mem_req_t;

    // fetched descriptor handed to the consumer
    typedef struct packed {
        logic [63:0] addr;
        logic [31:0] len;
        logic [15:0] id;
        logic        writable;
        logic        last;
    } desc_t;
endpackage : ring_pkg

// ---- hw/ring_engine.sv ----
/*
 * device end of a packed descriptor ring with event suppression.
 * assumes a memory port that answers each request with mem_ack and,
 * for reads, mem_rdata in the same cycle; the consumer takes descriptors
 * on desc_valid and reports completions through the register port.
 */
// Function
// - suppression codes: enable, disable, per slot
// - per-slot code only with event index
// - 15-bit offset names one ring slot
// - event wrap must match ring wrap
// - two le16 words: offset/wrap, flags
// - device reads driver structure, writes own; own kept only in dev_evt register, never written to memory
// - read peer structure after writing descriptors
// - 16-byte slots, 4-byte suppression, any size
// - fetch in ring order, write in completion
// - descriptor: addr64, len32, id16, flags16
// - no writes to readable buffers
// - consume only after available flag changes
// - no change after used flag written
// - repeated driver notifications are harmless
// - consume list in order, own limit
// - available when flags differ, used equal
// - device-writable marker value 2
module ring_engine
    import ring_pkg::*;
(
    input  wire logic        clk,          // 125 MHz
    input  wire logic        arst_n,       // async reset, low
    input  wire logic [3:0]  reg_addr,     // word index
    input  wire logic [31:0] reg_wdata,    // write data
    input  wire logic        reg_wr,       // write strobe
    input  wire logic        reg_rd,       // read strobe
    output logic      [31:0] reg_rdata,    // read data, cycle after strobe
    output mem_req_t         mem_req,      // memory request
    output logic             mem_valid,    // request valid
    input  wire logic        mem_ack,      // request taken
    input  wire logic [63:0] mem_rdata,    // read beat
    output desc_t            desc,         // fetched descriptor
    output logic             desc_valid,   // descriptor valid
    input  wire logic        desc_ready,   // consumer takes it
    output logic             used_notify   // one-cycle used-buffer notification
);
    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [2:0] {
        S_IDLE, S_FETCH0, S_FETCH1, S_HAND, S_USED, S_SUPP
    } state_t;
    state_t      state;          // engine state
    logic        run;            // queue enabled
    logic        evt_idx;        // event_index_feature negotiated
    logic [63:0] ring_base;      // ring base byte address
    logic [15:0] qsize;          // queue size, any value
    logic [63:0] drv_evt;        // driver suppression address
    logic [31:0] dev_evt;        // own suppression structure
    logic [14:0] avail_pos;      // next slot to fetch
    logic        avail_wrap;     // expected available wrap
    logic [14:0] used_pos;       // next slot to write used
    logic        used_wrap;      // used wrap counter
    logic [63:0] beat0;          // len, id, flags beat of fetched slot
    logic [3:0]  chain_len;      // descriptors in current list
    logic [15:0] done_id;        // completed buffer id
    logic [14:0] done_cnt;       // slots the completed list took
    logic        done_wr;        // data written to buffer
    logic        done_pend;      // completion waiting
    logic [3:0]  errors;         // sticky error bits
    logic [14:0] notify_pos;     // last driver notification
    logic        notify_wrap;    // last driver notification wrap
    logic [14:0] list_cnt;       // slots of list in flight
    logic [14:0] next_used_pos;  // used position after skip
    logic        next_used_wrap; // used wrap after skip
    logic [15:0] dflags;         // flags of fetched slot
    logic        is_avail;       // slot offered by driver
    logic [15:0] bflags;         // flags of held beat
    logic [14:0] last_used_pos;  // slot of latest used write
    logic        last_used_wrap; // wrap of latest used write

    // ************************************************************
    // descriptor decode
    // ************************************************************
    // flags word sits in top 16 bits of second beat, le layout
    assign dflags   = mem_rdata[63:48];
    // available when the flag equals the expected wrap and used differs
    assign is_avail = (dflags[FLAG_AVAIL] == avail_wrap) && (dflags[FLAG_USED] != avail_wrap);
    // flags of the beat held between the two fetch reads
    assign bflags   = beat0[63:48];

    // used position advance over the whole list, wrapping at qsize
    always_comb begin
        logic [15:0] sum;
        sum = 16'({1'b0, used_pos}) + 16'({1'b0, done_cnt});
        next_used_wrap = used_wrap;
        if (sum >= qsize) begin
            sum = sum - qsize;
            next_used_wrap = ~used_wrap;
        end
        next_used_pos = sum[14:0];
    end

    // ************************************************************
    // register port
    // ************************************************************
    // software configuration writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run       <= 1'b0;
            evt_idx   <= 1'b0;
            ring_base <= 64'h0;
            qsize     <= QSIZE_RST;
            drv_evt   <= 64'h0;
            dev_evt   <= 32'h0;
            notify_pos  <= 15'h0;
            notify_wrap <= 1'b0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                REG_CTRL:    begin
                    run     <= reg_wdata[CTRL_RUN];
                    evt_idx <= reg_wdata[CTRL_EVI];
                end
                // 16-byte alignment kept by forcing low bits
                REG_RING_LO: ring_base[31:0] <= {reg_wdata[31:4], 4'h0};
                REG_RING_HI: ring_base[63:32] <= reg_wdata;
                REG_QSIZE:   qsize <= reg_wdata[15:0];
                REG_DRV_EVT: drv_evt <= {32'h0, reg_wdata[31:2], 2'h0};
                // own structure: reserved bits forced zero, code 3 refused
                REG_DEV_EVT: if (reg_wdata[17:16] != 2'h3 &&
                                 (evt_idx || reg_wdata[17:16] != EVT_DESC)) begin
                    dev_evt <= {14'h0, reg_wdata[17:16], reg_wdata[15:0]};
                end
                // repeated notifications only overwrite the hint
                REG_NOTIFY:  begin
                    notify_pos  <= reg_wdata[14:0];
                    notify_wrap <= reg_wdata[15];
                end
                default:     ;
            endcase
        end
    end

    // completion report from consumer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            done_pend <= 1'b0;
            done_id   <= 16'h0;
            done_wr   <= 1'b0;
        end else if (reg_wr && reg_addr == REG_COMPLETE && !done_pend) begin
            done_pend <= 1'b1;
            done_id   <= reg_wdata[15:0];
            done_wr   <= reg_wdata[16];
        end else if (state == S_USED && mem_ack) begin
            done_pend <= 1'b0;
        end
    end

    // read data one cycle after strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL:    reg_rdata <= {30'h0, evt_idx, run};
                REG_RING_LO: reg_rdata <= ring_base[31:0];
                REG_RING_HI: reg_rdata <= ring_base[63:32];
                REG_QSIZE:   reg_rdata <= {16'h0, qsize};
                REG_DRV_EVT: reg_rdata <= drv_evt[31:0];
                REG_DEV_EVT: reg_rdata <= dev_evt;
                REG_STATUS:  reg_rdata <= {used_wrap, used_pos, avail_wrap, avail_pos};
                REG_ERRORS:  reg_rdata <= {28'h0, errors};
                REG_NOTIFY:  reg_rdata <= {16'h0, notify_wrap, notify_pos};
                default:     reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // ************************************************************
    // ring engine
    // ************************************************************
    // fetch in ring order, write used in completion order
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state      <= S_IDLE;
            avail_pos  <= 15'h0;
            avail_wrap <= 1'b1;
            used_pos   <= 15'h0;
            used_wrap  <= 1'b1;
            last_used_pos  <= 15'h0;
            last_used_wrap <= 1'b1;
            beat0      <= 64'h0;
            chain_len  <= 4'h0;
            list_cnt   <= 15'h0;
            done_cnt   <= 15'h0;
            errors     <= 4'h0;
            desc       <= '0;
            used_notify <= 1'b0;
        end else begin
            used_notify <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    if (done_pend) state <= S_USED;          // completions first
                    else if (run) state <= S_FETCH0;
                end
                // flags beat first: no payload is taken ahead of its flag
                S_FETCH0: if (mem_ack) begin
                    if (is_avail) begin
                        beat0 <= mem_rdata;                  // len, id, flags
                        state <= S_FETCH1;
                    end else begin
                        state <= S_IDLE;                     // poll again later
                    end
                end
                S_FETCH1: if (mem_ack) begin
                    desc.addr     <= mem_rdata;              // addr field
                    desc.len      <= beat0[31:0];
                    desc.id       <= beat0[47:32];
                    desc.writable <= bflags[FLAG_WR];
                    desc.last     <= ~bflags[FLAG_CONT];
                    // list limit and indirect-in-list checks
                    if (chain_len == 4'(MAX_CHAIN - 1) && bflags[FLAG_CONT])
                        errors[ERR_CHAIN] <= 1'b1;
                    if (bflags[FLAG_IND] && (bflags[FLAG_CONT] || chain_len != 4'h0))
                        errors[ERR_IND] <= 1'b1;
                    chain_len <= bflags[FLAG_CONT] ? chain_len + 4'h1 : 4'h0;
                    list_cnt  <= list_cnt + 15'h1;
                    // advance one slot, toggle wrap at end
                    if (16'({1'b0, avail_pos}) + 16'h1 >= qsize) begin
                        avail_pos  <= 15'h0;
                        avail_wrap <= ~avail_wrap;
                    end else begin
                        avail_pos <= avail_pos + 15'h1;
                    end
                    state <= S_HAND;
                end
                // hand over in chain order
                S_HAND: if (desc_ready) begin
                    if (desc.last) begin
                        done_cnt <= list_cnt;
                        list_cnt <= 15'h0;
                    end
                    state <= S_IDLE;
                end
                // single used write for the whole list, never touched again
                S_USED: if (mem_ack) begin
                    last_used_pos  <= used_pos;              // slot just marked used
                    last_used_wrap <= used_wrap;
                    used_pos  <= next_used_pos;
                    used_wrap <= next_used_wrap;
                    state     <= S_SUPP;
                end
                // read driver structure and decide notification
                S_SUPP: if (mem_ack) begin
                    unique case (mem_rdata[17:16])
                        EVT_ENABLE:  used_notify <= 1'b1;
                        EVT_DISABLE: used_notify <= 1'b0;
                        EVT_DESC:    used_notify <= evt_idx &&
                            (mem_rdata[14:0] == last_used_pos) &&
                            (mem_rdata[15] == last_used_wrap);
                        default:     errors[ERR_SUPP] <= 1'b1;
                    endcase
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
            if (ring_base[3:0] != 4'h0 || drv_evt[1:0] != 2'h0)
                errors[ERR_ALIGN] <= 1'b1;
        end
    end

    // ************************************************************
    // memory requests
    // ************************************************************
    // slot byte address is base plus 16 per slot
    always_comb begin
        mem_req   = '0;
        mem_valid = 1'b0;
        unique case (state)
            S_FETCH0: begin
                mem_valid    = 1'b1;
                mem_req.addr = ring_base + {45'h0, avail_pos, 4'h8};
            end
            S_FETCH1: begin
                mem_valid    = 1'b1;
                mem_req.addr = ring_base + {45'h0, avail_pos, 4'h0};
            end
            // used descriptor: id and flags with both flags equal to wrap
            S_USED: begin
                mem_valid     = 1'b1;
                mem_req.wr    = 1'b1;
                mem_req.addr  = ring_base + {45'h0, used_pos, 4'h8};
                mem_req.be    = 8'hff;
                mem_req.wdata = {used_wrap, 7'h0, used_wrap, 5'h0, done_wr, 1'b0,
                                 done_id, 32'h0};
            end
            // only the driver structure is read by the device
            S_SUPP: begin
                mem_valid    = 1'b1;
                mem_req.addr = drv_evt;
            end
            default: ;
        endcase
    end

    assign desc_valid = (state == S_HAND);

    // ************************************************************
    // checks
    // ************************************************************
    AST_USED_THEN_SUPP: assert property (@(posedge clk) disable iff (!arst_n)
        (state == S_USED && mem_ack) |=> state == S_SUPP)
        else $error("used write not followed by suppression read");
    AST_NO_NOTIFY_DISABLED: assert property (@(posedge clk) disable iff (!arst_n)
        (state == S_SUPP && mem_ack && mem_rdata[17:16] == EVT_DISABLE) |=> !used_notify)
        else $error("notification despite disable");
    AST_NOTIFY_ENABLED: assert property (@(posedge clk) disable iff (!arst_n)
        (state == S_SUPP && mem_ack && mem_rdata[17:16] == EVT_ENABLE) |=> used_notify)
        else $error("missing notification");
    AST_DESC_NEEDS_EVI: assert property (@(posedge clk) disable iff (!arst_n)
        (state == S_SUPP && mem_ack && mem_rdata[17:16] == EVT_DESC && !evt_idx)
        |=> !used_notify)
        else $error("per-slot event without feature");
    AST_FETCH_AVAIL: assert property (@(posedge clk) disable iff (!arst_n)
        (state == S_FETCH0 && mem_ack && !is_avail) |=> state == S_IDLE && $stable(avail_pos))
        else $error("consumed slot not available");
    AST_DESC_SLOT_HIT: assert property (@(posedge clk) disable iff (!arst_n)
        (state == S_SUPP && mem_ack && mem_rdata[17:16] == EVT_DESC && evt_idx &&
         mem_rdata[14:0] == last_used_pos && mem_rdata[15] == last_used_wrap)
        |=> used_notify)
        else $error("per-slot event missed");
    AST_DESC_WRAP_MISS: assert property (@(posedge clk) disable iff (!arst_n)
        (state == S_SUPP && mem_ack && mem_rdata[17:16] == EVT_DESC &&
         mem_rdata[15] != last_used_wrap) |=> !used_notify)
        else $error("per-slot event despite wrap mismatch");
    AST_SUPP_READ_ONLY: assert property (@(posedge clk) disable iff (!arst_n)
        (state == S_SUPP && mem_valid) |-> !mem_req.wr)
        else $error("write to driver structure");
    AST_USED_FLAGS_EQ: assert property (@(posedge clk) disable iff (!arst_n)
        (mem_valid && mem_req.wr) |-> mem_req.wdata[63] == mem_req.wdata[55])
        else $error("used flags differ");
    AST_SLOT_ALIGN: assert property (@(posedge clk) disable iff (!arst_n)
        (mem_valid && state != S_SUPP) |-> mem_req.addr[2:0] == 3'h0)
        else $error("misaligned slot access");
endmodule // ring_engine

// ---- verif/ring_mem_model.sv ----
/*
 * behavioural shared memory on the driver side of the ring engine.
 * assumes one engine request at a time, held until acknowledged.
 */
module ring_mem_model
    import ring_pkg::*;
(
    input  wire logic        clk,       // bench clock
    input  wire logic        arst_n,    // async reset, low
    input  mem_req_t         mem_req,   // engine request
    input  wire logic        mem_valid, // request pending
    input  wire logic [3:0]  lat,       // answer delay, 1 or more
    output logic             mem_ack,   // request taken
    output logic      [63:0] mem_rdata  // read beat, with ack only
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] mem [logic [60:0]];    // sparse 64-bit beats
    logic [3:0]  wait_cnt;              // cycles waited
    logic [63:0] rd_q;                  // beat looked up ahead
    logic [63:0] last_rd;               // last beat handed out
    logic [63:0] wr_addr;               // last write address
    logic [63:0] wr_data;               // last write beat
    int          n_wr;                  // writes taken
    // unwritten beats read as zero, as a cleared ring does
    function automatic logic [63:0] peek(input logic [63:0] a);
        return mem.exists(a[63:3]) ? mem[a[63:3]] : 64'h0;
    endfunction
    task automatic poke(input logic [63:0] a, input logic [63:0] d);
        mem[a[63:3]] = d;
    endtask
    assign mem_ack = mem_valid && (wait_cnt >= lat);
    // outside an answer the line shows the inverse of the last beat
    assign mem_rdata = (mem_ack && !mem_req.wr) ? rd_q : ~last_rd;
    // delay count, lookahead and byte-masked writes
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt <= 4'h0;
            last_rd  <= 64'h0;
            n_wr = 0;
        end else begin
            rd_q     <= peek(mem_req.addr);
            wait_cnt <= (mem_valid && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
            if (mem_ack && !mem_req.wr) begin
                last_rd <= rd_q;
            end
            if (mem_ack && mem_req.wr) begin
                wr_addr = mem_req.addr;
                wr_data = mem_req.wdata;
                n_wr++;
                for (int b = 0; b < 8; b++) begin
                    if (mem_req.be[b]) begin
                        mem[wr_addr[63:3]][8*b +: 8] = wr_data[8*b +: 8];
                    end
                end
            end
        end
    end
endmodule // ring_mem_model

// ---- verif/tb_top.sv ----
/*
 * self-checking bench for the ring engine: register tasks, descriptor
 * and completion sequences against a behavioural shared memory.
 * assumes status packs {used_wrap, used_pos, avail_wrap, avail_pos}.
 */
module tb_top
    import ring_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, arst_n;           // clock, reset
    logic [3:0]  reg_addr, lat;         // register index, memory delay
    logic [31:0] reg_wdata, reg_rdata;  // register data
    logic        reg_wr, reg_rd;        // strobes
    mem_req_t    mem_req;               // memory request
    logic        mem_valid, mem_ack;    // memory handshake
    logic [63:0] mem_rdata;             // memory beat
    desc_t       desc;                  // fetched descriptor
    logic        desc_valid, desc_ready, used_notify;
    int          n_fail, num_checks, n_notes;
    ring_engine DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
        .mem_valid(mem_valid), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .desc(desc),
        .desc_valid(desc_valid), .desc_ready(desc_ready), .used_notify(used_notify));
    ring_mem_model mem (.clk(clk), .arst_n(arst_n), .mem_req(mem_req), .mem_valid(mem_valid),
        .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(128'(reg_rdata), 128'(exp));
    endtask
    // wait for an offered descriptor, compare it, then take it
    task automatic take_desc(input logic [63:0] a, input logic [31:0] l,
                             input logic [15:0] id, input logic w, input logic lst);
        desc_t e;
        e = '{addr: a, len: l, id: id, writable: w, last: lst};
        #1;
        for (int i = 0; i < 200 && desc_valid !== 1'b1; i++) @(posedge clk) #1;
        chk(128'(desc_valid), 128'(1'b1));
        chk(128'(desc), 128'(e));
        @(posedge clk);
        desc_ready <= 1'b1;
        @(posedge clk);
        desc_ready <= 1'b0;
    endtask
    // report a completion, then check the single used write and notifications
    task automatic finish_buf(input logic [15:0] id, input logic w, input logic [63:0] a,
                              input logic [15:0] f, input int nn);
        int w0;
        w0 = mem.n_wr;
        reg_write(REG_COMPLETE, {15'h0, w, id});
        for (int i = 0; i < 200 && mem.n_wr == w0; i++) @(posedge clk);
        repeat (30) @(posedge clk);
        chk(128'(mem.n_wr - w0), 128'(1));
        chk(128'(mem.wr_addr), 128'(a));
        chk(128'(mem.wr_data), 128'({f, id, 32'h0}));
        chk(128'(n_notes), 128'(nn));
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // count one-cycle notification pulses
    always @(posedge clk) begin
        if (used_notify === 1'b1) n_notes++;
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report();
    end
    // main sequence
    initial begin
        {arst_n, reg_addr, reg_wdata, reg_wr, reg_rd, desc_ready} = '0;
        lat = 4'h1;
        {n_fail, num_checks, n_notes} = '0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        reg_check(REG_QSIZE, {16'h0, QSIZE_RST});
        reg_check(REG_STATUS, 32'h8000_8000);
        reg_check(4'hf, 32'h0);
        reg_write(REG_RING_LO, 32'h0000_1000);
        reg_write(REG_RING_HI, 32'h0);
        reg_write(REG_QSIZE, 32'h3);
        reg_write(REG_DRV_EVT, 32'h0000_2000);
        reg_write(REG_CTRL, 32'h1);
        reg_check(REG_ERRORS, 32'h0);
        reg_write(REG_DEV_EVT, 32'h0001_0000);
        reg_write(REG_DEV_EVT, 32'h0002_0004);
        reg_write(REG_DEV_EVT, 32'h0003_0000);
        reg_check(REG_DEV_EVT, 32'h0001_0000);
        repeat (40) @(posedge clk);
        chk(128'(desc_valid), 128'(1'b0));
        mem.poke(64'h1000, 64'ha000);
        mem.poke(64'h1008, {16'h0082, 16'h0005, 32'h40});
        take_desc(64'ha000, 32'h40, 16'h5, 1'b1, 1'b1);
        finish_buf(16'h5, 1'b1, 64'h1008, 16'h8082, 1);
        lat <= 4'h5;
        mem.poke(64'h2000, 64'h1_0000);
        mem.poke(64'h1020, 64'hb000);
        mem.poke(64'h1028, {16'h0082, 16'h0007, 32'h20});
        mem.poke(64'h1010, 64'hc000);
        mem.poke(64'h1018, {16'h0081, 16'h0000, 32'h10});
        take_desc(64'hc000, 32'h10, 16'h0, 1'b0, 1'b0);
        take_desc(64'hb000, 32'h20, 16'h7, 1'b1, 1'b1);
        finish_buf(16'h7, 1'b1, 64'h1018, 16'h8082, 1);
        reg_write(REG_CTRL, 32'h3);
        reg_write(REG_DEV_EVT, 32'h0002_0004);
        reg_check(REG_DEV_EVT, 32'h0002_0004);
        mem.poke(64'h2000, 64'h2_0000);
        mem.poke(64'h1000, 64'he000);
        mem.poke(64'h1008, {16'h8000, 16'h0009, 32'h8});
        take_desc(64'he000, 32'h8, 16'h9, 1'b0, 1'b1);
        finish_buf(16'h9, 1'b0, 64'h1008, 16'h0000, 2);
        mem.poke(64'h2000, 64'h2_8001);
        mem.poke(64'h1010, 64'hf000);
        mem.poke(64'h1018, {16'h8002, 16'h000b, 32'h4});
        take_desc(64'hf000, 32'h4, 16'hb, 1'b1, 1'b1);
        finish_buf(16'hb, 1'b1, 64'h1018, 16'h0002, 2);
        reg_write(REG_NOTIFY, 32'h0000_0002);
        reg_write(REG_NOTIFY, 32'h0000_0002);
        repeat (20) @(posedge clk);
        chk(128'(desc_valid), 128'(1'b0));
        reg_check(REG_STATUS, 32'h0002_0002);
        reg_check(REG_NOTIFY, 32'h0000_0002);
        final_report();
    end
endmodule // tb_top
